/* verification/boundary_scan_tap_port_tb.sv */
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none

module boundary_scan_tap_port_tb;
    import mqt_pkg::*;
    logic mclk;
    logic rst;
    logic tck;
    mqt_pins_s pins;
    mqt_pins_s pinDriven;
    mqt_tdo_s tdo;
    mqt_tdo_s seen;
    logic sysTapReady;
    logic sysTapInReset;
    logic [31:0] d;
    int miscompares;
    int cmp_count;

    // system clock, 5 ns period
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    mqt_tap dut (.mclk(mclk), .rst(rst), .tck(tck), .pins(pins),
        .pinDriven(pinDriven), .tdo(tdo), .sysTapReady(sysTapReady),
        .sysTapInReset(sysTapInReset));

    mqt_tester tester (.tck(tck), .pins(pins), .pinDriven(pinDriven),
        .tdo(tdo));

    task automatic check_bit(input string what, input logic exp,
                             input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %0b seen %0b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_word(input string what, input logic [31:0] exp,
                              input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    // status crosses through a synchroniser, so allow it a few cycles
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    // mode-select walk, lsb first; output must stay released throughout
    task automatic walk(input logic [7:0] bits, input int len);
        for (int i = 0; i < len; i++)
        begin
            tester.cycle(bits[i], 1'b1, seen);
            check_bit("tdo released", 1'b1, seen.oeN);
        end
    endtask : walk

    // full scan from run-test-idle back to run-test-idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        dout = '0;
        walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int i = 0; i < n; i++)
        begin
            tester.cycle(i == n - 1, din[i], seen);
            dout[i] = seen.data;
            check_bit("tdo driven", 1'b0, seen.oeN);
        end
        walk(8'h01, 2);
    endtask : scan

    task automatic t_unreset();
        walk(8'h03, 8);
        tick(8);
        check_bit("ready before reset", 1'b0, sysTapReady);
        $display("test unreset done");
    endtask : t_unreset

    task automatic t_tms_reset();
        walk(8'h1F, 5);
        tick(8);
        check_bit("in reset", 1'b1, sysTapInReset);
        check_bit("ready", 1'b1, sysTapReady);
        walk(8'h00, 1);
        tick(8);
        check_bit("left reset", 1'b0, sysTapInReset);
        $display("test tms reset done");
    endtask : t_tms_reset

    // bits pushed through the 4-bit instruction path reappear 4 later
    task automatic t_ir_bypass();
        scan(1'b1, 8, {24'h0, IR_BYPASS, 4'hA}, d);
        check_word("ir capture", {28'h0, IR_CAPTURE}, {28'h0, d[3:0]});
        check_word("ir pass", 32'hA, {28'h0, d[7:4]});
        scan(1'b0, 4, 32'hB, d);
        check_word("bypass out", 32'h6, d);
        $display("test ir bypass done");
    endtask : t_ir_bypass

    // test reset tied to the master reset; no test clock runs meanwhile
    task automatic t_trst();
        rst = 1'b1;
        tester.setPins(1'b0, 3'h7);
        tick(8);
        check_bit("ready in reset", 1'b0, sysTapReady);
        rst = 1'b0;
        tick(8);
        check_bit("async reset", 1'b1, sysTapInReset);
        check_bit("ready after trst", 1'b1, sysTapReady);
        tester.setPins(1'b1, 3'h7);
        walk(8'h00, 1);
        scan(1'b0, 32, 32'h0, d);
        check_word("id read", ID_DEFAULT, d);
        $display("test trst done");
    endtask : t_trst

    task automatic t_float();
        tester.setPins(1'b0, '{tms: 1'b1, tdi: 1'b1, trstN: 1'b0});
        tick(8);
        check_bit("floating trst", 1'b0, sysTapInReset);
        tester.setPins(1'b1, '{tms: 1'b0, tdi: 1'b1, trstN: 1'b1});
        walk(8'h00, 5);
        tick(8);
        check_bit("floating tms", 1'b1, sysTapInReset);
        tester.setPins(1'b1, '{tms: 1'b1, tdi: 1'b0, trstN: 1'b1});
        walk(8'h00, 1);
        scan(1'b1, 8, 32'h0, d);
        check_word("floating tdi", 32'hF, {28'h0, d[7:4]});
        tester.setPins(1'b1, 3'h7);
        $display("test float done");
    endtask : t_float

    // main sequence
    initial
    begin
        rst = 1'b1;
        miscompares = 0;
        cmp_count = 0;
        tester.cycle(1'b0, 1'b1, seen);
        tick(10);
        rst = 1'b0;
        tick(2);
        t_unreset();
        t_tms_reset();
        t_ir_bypass();
        t_trst();
        t_float();
        check_word("rise changes", 32'h0, tester.riseChanges);
        end_of_test();
    end

    // watchdog well past the expected run of under a microsecond
    initial
    begin
        #100000;
        miscompares++;
        $display("watchdog expired");
        end_of_test();
    end
endmodule : boundary_scan_tap_port_tb
`default_nettype wire

/* verification/mqt_tester.sv */
// tester model that clocks the scan port and drives its test pins
`timescale 1ns/1ps
`default_nettype none

module mqt_tester
    import mqt_pkg::*;
(
    // test clock and pins towards the port
    output logic tck,
    output mqt_pkg::mqt_pins_s pins,
    output mqt_pkg::mqt_pins_s pinDriven,
    // serial output from the port
    input wire mqt_pkg::mqt_tdo_s tdo
);
    int riseChanges;

    // idle: clock parked low, everything driven, test reset released
    initial
    begin
        tck = 1'b0;
        pins = 3'h7;
        pinDriven = 3'h7;
        riseChanges = 0;
    end

    // test reset level and which pins are driven; a floating pin is
    // given the level opposite its pull-up so the port must honour it
    task automatic setPins(input logic trstN, input mqt_pins_s drv);
        pins.trstN = trstN;
        pinDriven = drv;
    endtask : setPins

    // one test clock period; returns what stood on the output at the rise
    task automatic cycle(input logic tms, input logic tdi,
                         output mqt_tdo_s seen);
        pins.tms = pinDriven.tms ? tms : 1'b0;
        pins.tdi = pinDriven.tdi ? tdi : 1'b0;
        #3;
        seen = tdo;
        tck = 1'b1;
        #1;
        // output must not move on the rising edge
        if (tdo !== seen)
            riseChanges++;
        #2;
        tck = 1'b0;
    endtask : cycle
endmodule : mqt_tester
`default_nettype wire

/* verilog/mqt_pkg.sv */
// shared constants and carrier types for the boundary-scan test port
package mqt_pkg;

    // instruction register layout and codes
    localparam int IR_WIDTH = 4;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] IR_IDCODE = 4'h2;
    localparam logic [3:0] IR_BYPASS = 4'hF;

    // identification register layout
    localparam int ID_WIDTH = 32;
    localparam logic [31:0] ID_DEFAULT = 32'h0000_1001;

    // consecutive mode-select highs that force the reset state
    localparam logic [2:0] TMS_RESET_COUNT = 3'h5;
    localparam logic [2:0] TMS_RESET_LAST = 3'h4;

    // width of the status word crossing into the system clock
    localparam int SYNC_WIDTH = 2;
    localparam int SYNC_READY_BIT = 1;
    localparam int SYNC_RESET_BIT = 0;

    // sixteen controller states
    typedef enum logic [3:0] {
        TLR, RTI,
        SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
        SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
    } mqt_tap_state_e;

    // test inputs as they sit on the pins
    typedef struct packed {
        logic tms;
        logic tdi;
        logic trstN;
    } mqt_pins_s;

    // serial output with its enable, enable low while driving
    typedef struct packed {
        logic data;
        logic oeN;
    } mqt_tdo_s;

endpackage : mqt_pkg

/* verilog/mqt_sync.sv */
// three-stage synchroniser that passes a bit once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module mqt_sync #(
    parameter int W = 1
) (
    // clock and reset of the receiving domain
    input wire logic clk,
    input wire logic rst,
    // word from the foreign domain
    input wire logic [W-1:0] async,
    // filtered word
    output logic [W-1:0] q
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] next_q;

    // stage one feeds stage two only, so metastability has a cycle to settle
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            next_q[i] = (stage2[i] == stage3[i]) ? stage3[i] : q[i];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            q <= '0;
        end
        else
        begin
            stage1 <= async;
            stage2 <= stage1;
            stage3 <= stage2;
            q <= next_q;
        end
    end

endmodule : mqt_sync

`default_nettype wire

/* verilog/mqt_tap.sv */
// boundary-scan test access port with instruction, identification and bypass
`timescale 1ns/1ps
`default_nettype none

module mqt_tap #(
    // arbitrary identification value, bit zero set as scan requires
    parameter logic [31:0] ID_CODE = mqt_pkg::ID_DEFAULT
) (
    // system clock domain
    input wire logic mclk,
    input wire logic rst,
    // test clock and pins
    input wire logic tck,
    input wire mqt_pkg::mqt_pins_s pins,
    input wire mqt_pkg::mqt_pins_s pinDriven,
    // serial output pin, three-state by enable
    output mqt_pkg::mqt_tdo_s tdo,
    // controller status seen from the system clock
    output logic sysTapReady,
    output logic sysTapInReset
);
    import mqt_pkg::*;

    logic tmsEff;
    logic tdiEff;
    logic trstNEff;
    mqt_tap_state_e state;
    mqt_tap_state_e next_state;
    logic [2:0] tmsHighCnt;
    logic [2:0] next_tmsHighCnt;
    logic resetSeen;
    logic next_resetSeen;
    logic tlrFlag;
    logic next_tlrFlag;
    logic [IR_WIDTH-1:0] irShift;
    logic [IR_WIDTH-1:0] next_irShift;
    logic [ID_WIDTH-1:0] idShift;
    logic [ID_WIDTH-1:0] next_idShift;
    logic bypassBit;
    logic next_bypassBit;
    logic [IR_WIDTH-1:0] irActive;
    logic [IR_WIDTH-1:0] next_irActive;
    mqt_tdo_s next_tdo;
    logic isShift;
    logic serialOut;
    logic [SYNC_WIDTH-1:0] statusAsync;
    logic [SYNC_WIDTH-1:0] statusSync;

    // a floating pin reads high, as a pull-up on the pad would make it
    assign tmsEff = pinDriven.tms ? pins.tms : 1'b1;
    assign tdiEff = pinDriven.tdi ? pins.tdi : 1'b1;
    assign trstNEff = pinDriven.trstN ? pins.trstN : 1'b1;

    // controller next state from mode-select
    always_comb
    begin
        next_state = state;
        unique case (state)
            TLR: next_state = tmsEff ? TLR : RTI;
            RTI: next_state = tmsEff ? SEL_DR : RTI;
            SEL_DR: next_state = tmsEff ? SEL_IR : CAP_DR;
            CAP_DR: next_state = tmsEff ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: next_state = tmsEff ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: next_state = tmsEff ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR: next_state = tmsEff ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: next_state = tmsEff ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR: next_state = tmsEff ? SEL_DR : RTI;
            SEL_IR: next_state = tmsEff ? TLR : CAP_IR;
            CAP_IR: next_state = tmsEff ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: next_state = tmsEff ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: next_state = tmsEff ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR: next_state = tmsEff ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: next_state = tmsEff ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR: next_state = tmsEff ? SEL_IR : RTI;
        endcase
        // only a real reset counts: an unknown or lucky power-up state
        // must not unlock the output
        next_resetSeen = resetSeen;
        // fifth high forces reset even from an unknown power-up state
        if (tmsEff && tmsHighCnt == TMS_RESET_LAST)
        begin
            next_state = TLR;
            next_resetSeen = 1'b1;
        end
        next_tlrFlag = (next_state == TLR);
        if (tmsEff)
        begin
            next_tmsHighCnt = (tmsHighCnt == TMS_RESET_LAST) ? tmsHighCnt
                : 3'(tmsHighCnt + 3'h1);
        end
        else
        begin
            next_tmsHighCnt = 3'h0;
        end
    end

    // controller state, cleared at once by test reset
    always_ff @(posedge tck or negedge trstNEff)
    begin
        if (!trstNEff)
        begin
            state <= TLR;
            tlrFlag <= 1'b1;
        end
        else
        begin
            state <= next_state;
            tlrFlag <= next_tlrFlag;
        end
    end

    // count of highs and the reset-seen flag; test reset marks the flag at
    // once and wins over the system reset, which may be tied to it
    always_ff @(posedge tck or posedge rst or negedge trstNEff)
    begin
        if (!trstNEff)
        begin
            tmsHighCnt <= 3'h0;
            resetSeen <= 1'b1;
        end
        else if (rst)
        begin
            tmsHighCnt <= 3'h0;
            resetSeen <= 1'b0;
        end
        else
        begin
            tmsHighCnt <= next_tmsHighCnt;
            resetSeen <= next_resetSeen;
        end
    end

    // shift paths: capture then shift toward bit zero
    always_comb
    begin
        next_irShift = irShift;
        next_idShift = idShift;
        next_bypassBit = bypassBit;
        unique case (state)
            CAP_IR: next_irShift = IR_CAPTURE;
            SHIFT_IR: next_irShift = {tdiEff, irShift[IR_WIDTH-1:1]};
            CAP_DR:
            begin
                next_bypassBit = 1'b0;
                if (irActive == IR_IDCODE)
                begin
                    next_idShift = ID_CODE;
                end
            end
            SHIFT_DR:
            begin
                // any instruction other than identify selects bypass
                if (irActive == IR_IDCODE)
                begin
                    next_idShift = {tdiEff, idShift[ID_WIDTH-1:1]};
                end
                else
                begin
                    next_bypassBit = tdiEff;
                end
            end
            default:
            begin
                next_irShift = irShift;
            end
        endcase
    end

    always_ff @(posedge tck or negedge trstNEff)
    begin
        if (!trstNEff)
        begin
            irShift <= IR_CAPTURE;
            idShift <= '0;
            bypassBit <= 1'b0;
        end
        else
        begin
            irShift <= next_irShift;
            idShift <= next_idShift;
            bypassBit <= next_bypassBit;
        end
    end

    // output side: selected bit and its enable
    assign isShift = (state == SHIFT_IR) || (state == SHIFT_DR);
    assign serialOut = (state == SHIFT_IR) ? irShift[0]
        : (irActive == IR_IDCODE) ? idShift[0] : bypassBit;

    always_comb
    begin
        next_tdo.data = serialOut;
        // enable only in shift states, and never before a proper reset
        next_tdo.oeN = !(isShift && resetSeen);
        next_irActive = irActive;
        if (state == TLR)
        begin
            next_irActive = IR_IDCODE;
        end
        else if (state == UPDATE_IR)
        begin
            next_irActive = irShift;
        end
    end

    // falling edge half: half a period of hold for the far end's sampler
    always_ff @(negedge tck or negedge trstNEff or posedge rst)
    begin
        if (rst || !trstNEff)
        begin
            tdo.data <= 1'b0;
            tdo.oeN <= 1'b1;
            irActive <= IR_IDCODE;
        end
        else
        begin
            tdo <= next_tdo;
            irActive <= next_irActive;
        end
    end

    // status crossing into the system clock, level only
    assign statusAsync[SYNC_READY_BIT] = resetSeen;
    assign statusAsync[SYNC_RESET_BIT] = tlrFlag;

    mqt_sync #(
        .W(SYNC_WIDTH)
    ) u_status_sync (
        .clk(mclk),
        .rst(rst),
        .async(statusAsync),
        .q(statusSync)
    );

    assign sysTapReady = statusSync[SYNC_READY_BIT];
    assign sysTapInReset = statusSync[SYNC_RESET_BIT];

    // data-out as it stood at the last rise, for the falling-edge check
    mqt_tdo_s tdoAtRise;

    always_ff @(posedge tck)
    begin
        tdoAtRise <= tdo;
    end

    // checks on the test clock, except the test-reset check on the system clock
    property p_five_high;
        @(posedge tck) disable iff (!trstNEff || rst)
        tmsEff [*5] |=> state == TLR;
    endproperty
    a_five_high: assert property (p_five_high)
        else $error("five mode-select highs did not reach reset");

    property p_step_capture_dr;
        @(posedge tck) disable iff (!trstNEff || rst)
        (state == SEL_DR) && !tmsEff ##1 !tmsEff |=> state == SHIFT_DR;
    endproperty
    a_step_capture_dr: assert property (p_step_capture_dr)
        else $error("select-dr and two lows did not reach shift-dr");

    property p_step_ir;
        @(posedge tck) disable iff (!trstNEff || rst)
        (state == SHIFT_IR) && tmsEff ##1 tmsEff |=> state == UPDATE_IR;
    endproperty
    a_step_ir: assert property (p_step_ir)
        else $error("two highs from shift-ir did not reach update-ir");

    property p_oe_shift;
        @(posedge tck) disable iff (!trstNEff || rst)
        tdo.oeN == !(isShift && resetSeen);
    endproperty
    a_oe_shift: assert property (p_oe_shift)
        else $error("output enable does not follow shift states");

    property p_hiz_before_reset;
        @(posedge tck) disable iff (!trstNEff || rst)
        !resetSeen |-> tdo.oeN;
    endproperty
    a_hiz_before_reset: assert property (p_hiz_before_reset)
        else $error("output driven before a proper reset");

    property p_ir_shift;
        @(posedge tck) disable iff (!trstNEff || rst)
        state == SHIFT_IR |=> irShift == {$past(tdiEff), $past(irShift[3:1])};
    endproperty
    a_ir_shift: assert property (p_ir_shift)
        else $error("instruction register did not shift data-in");

    property p_ir_out;
        @(posedge tck) disable iff (!trstNEff || rst)
        (state == SHIFT_IR) && $past(state == SHIFT_IR) |-> tdo.data == irShift[0];
    endproperty
    a_ir_out: assert property (p_ir_out)
        else $error("data-out does not show instruction bit zero");

    property p_id_capture;
        @(posedge tck) disable iff (!trstNEff || rst)
        (state == CAP_DR) && (irActive == IR_IDCODE) |=> idShift == ID_CODE;
    endproperty
    a_id_capture: assert property (p_id_capture)
        else $error("identification value not captured");

    property p_out_on_fall;
        @(negedge tck) disable iff (!trstNEff || rst)
        (tdo.oeN == tdoAtRise.oeN)
            && (tdo.oeN || tdo.data == tdoAtRise.data);
    endproperty
    a_out_on_fall: assert property (p_out_on_fall)
        else $error("data-out moved on a rising edge");

    property p_async_reset;
        @(posedge mclk) disable iff (rst)
        !trstNEff |-> state == TLR;
    endproperty
    a_async_reset: assert property (p_async_reset)
        else $error("test reset did not force the reset state");

endmodule : mqt_tap

`default_nettype wire
